// *** rtl/xtb_pkg.sv ***
// Package for the board-level parity test block: chain sizes, pin map, strap sequencing
package xtb_pkg;

    localparam int NUM_CHAINS      = 10;
    localparam int CHAIN0_LEN      = 75;
    localparam int CHAIN1_LEN      = 60;
    localparam int CHAIN2_LEN      = 43;
    localparam int CHAIN3_LEN      = 45;
    // Chains 4 to 9 are sized as parameters of the top module
    localparam int CHAIN_MAX_LEN   = 75;
    localparam int CHAIN_A_STB_NUM = 9;
    localparam int CHAIN_B_STB_NUM = 9;
    localparam int STB_A_CHAIN     = 4;
    localparam int STB_B_CHAIN     = 5;
    // Cycles the tester waits after strap release before testing
    localparam int SETTLE_CYCLES   = 32;
    localparam logic [5:0] SETTLE_CNT_MAX = 6'h20;

    // Result bundle driven on the ten shared strap/select pins
    typedef struct packed {
        logic bus_speed_select_0;
        logic bus_speed_select_1;
        logic reserved_test_point_6;
        logic port_enable_strap_n;
        logic reserved_test_point_4;
        logic lane_reversal_strap;
        logic primary_present_strap_n;
        logic xor_test_strap;
        logic all_float_test_pin;
        logic bus_speed_select_2;
    } xtb_pins_t;

    typedef enum logic [1:0] {
        XTB_IDLE   = 2'b00,
        XTB_ARMED  = 2'b01,
        XTB_ACTIVE = 2'b10
    } xtb_mode_t;

    typedef struct packed {
        xtb_mode_t            mode;
        logic                 rst_prev;
        logic [5:0]           settle;
        logic                 ready;
        logic [NUM_CHAINS-1:0] result;
        logic                 test_mode;
        logic                 strobe_err;
    } xtb_state_t;

    // Parity of a chain's member pins, one XOR stage per member
    function automatic logic xtb_parity(input logic [CHAIN_MAX_LEN-1:0] pins, input int len);
        logic acc;
        acc = 1'b0;
        for (int i = 0; i < CHAIN_MAX_LEN; i++) begin
            if (i < len) begin
                acc = acc ^ pins[i];
            end
        end
        return acc;
    endfunction : xtb_parity

endpackage : xtb_pkg

// *** rtl/xtb_xor_tree_test.sv ***
// Parity-tree board test logic: mode entry, ten XOR chains, result pin drive
//////////////////////////////////////////////////////////////////////////////
// How it works
// - Both straps low when external reset rises puts the device in test mode.
// - Each chain is an XOR cascade taking every member pin once.
// - Ten independent chains, each with its own result output.
// - Results drive fixed strap and select pins, chain 0 through 9.
// - Each result is visible on its single assigned output pin.
// - Chains 0 and 1 cover processor bus pins, 75 and 60 members.
// - Chains 2 and 3 cover memory channel pins, 43 and 45 members.
module xtb_xor_tree_test #(
    parameter int CHAIN4_LEN = 49,
    parameter int CHAIN5_LEN = 50,
    parameter int CHAIN6_LEN = 43,
    parameter int CHAIN7_LEN = 40,
    parameter int CHAIN8_LEN = 64,
    parameter int CHAIN9_LEN = 16
) (
    input  wire logic                                 clk,
    input  wire logic                                 nrst,
    input  wire logic                                 power_good_in,
    input  wire logic                                 external_reset_in_n,
    input  wire xtb_pkg::xtb_pins_t                   strap_in,
    input  wire logic [xtb_pkg::CHAIN_MAX_LEN-1:0]    chain_pins [xtb_pkg::NUM_CHAINS],
    input  wire logic [xtb_pkg::CHAIN_A_STB_NUM-1:0]  chan_a_strobe_true,
    input  wire logic [xtb_pkg::CHAIN_A_STB_NUM-1:0]  chan_a_strobe_comp,
    input  wire logic [xtb_pkg::CHAIN_B_STB_NUM-1:0]  chan_b_strobe_true,
    input  wire logic [xtb_pkg::CHAIN_B_STB_NUM-1:0]  chan_b_strobe_comp,
    output xtb_pkg::xtb_pins_t                        result_out,
    output xtb_pkg::xtb_pins_t                        result_oe,
    output logic                                      test_mode,
    output logic                                      test_ready,
    output logic                                      strobe_pair_err
);
    import xtb_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // Reset release through two flops
    logic rst_meta_r;
    logic rst_sync_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Chain lengths and parity
    int lens [NUM_CHAINS];
    logic [NUM_CHAINS-1:0] parity;

    always_comb begin
        lens[0] = CHAIN0_LEN;
        lens[1] = CHAIN1_LEN;
        lens[2] = CHAIN2_LEN;
        lens[3] = CHAIN3_LEN;
        lens[4] = CHAIN4_LEN;
        lens[5] = CHAIN5_LEN;
        lens[6] = CHAIN6_LEN;
        lens[7] = CHAIN7_LEN;
        lens[8] = CHAIN8_LEN;
        lens[9] = CHAIN9_LEN;
        for (int c = 0; c < NUM_CHAINS; c++) begin
            parity[c] = xtb_parity(chain_pins[c], lens[c]);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // State
    xtb_state_t st_r;
    xtb_state_t st_nxt;
    logic       stb_bad;

    // True strobes are outside every chain; only the pairing is watched
    assign stb_bad = |(chan_a_strobe_true ~^ chan_a_strobe_comp)
                   | |(chan_b_strobe_true ~^ chan_b_strobe_comp);

    always_comb begin
        st_nxt          = st_r;
        st_nxt.rst_prev = external_reset_in_n;
        unique case (st_r.mode)
            XTB_IDLE: begin
                // Straps are only meaningful once power is good
                if (power_good_in && !external_reset_in_n) begin
                    st_nxt.mode = XTB_ARMED;
                end
            end
            XTB_ARMED: begin
                if (!power_good_in) begin
                    st_nxt.mode = XTB_IDLE;
                end else if (external_reset_in_n && !st_r.rst_prev) begin
                    if (!strap_in.xor_test_strap && !strap_in.primary_present_strap_n) begin
                        st_nxt.mode   = XTB_ACTIVE;
                        st_nxt.settle = 6'h00;
                    end else begin
                        st_nxt.mode = XTB_IDLE;
                    end
                end
            end
            XTB_ACTIVE: begin
                // A new reset or loss of power leaves test mode
                if (!power_good_in || !external_reset_in_n) begin
                    st_nxt.mode  = XTB_IDLE;
                    st_nxt.ready = 1'b0;
                end else if (st_r.settle != SETTLE_CNT_MAX) begin
                    st_nxt.settle = st_r.settle + 6'h01;
                end
            end
            default: st_nxt.mode = XTB_IDLE;
        endcase
        st_nxt.test_mode  = (st_nxt.mode == XTB_ACTIVE);
        st_nxt.ready      = st_nxt.test_mode && (st_nxt.settle == SETTLE_CNT_MAX);
        st_nxt.result     = st_nxt.test_mode ? parity : '0;
        st_nxt.strobe_err = st_r.ready && stb_bad;
    end

    always_ff @(posedge clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            st_r <= '{mode: XTB_IDLE, rst_prev: 1'b0, settle: 6'h00, ready: 1'b0,
                      result: '0, test_mode: 1'b0, strobe_err: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Outputs, all from the state flops; bit order matches xtb_pins_t
    assign result_out      = xtb_pins_t'(st_r.result);
    assign result_oe       = st_r.test_mode ? '1 : '0;
    assign test_mode       = st_r.test_mode;
    assign test_ready      = st_r.ready;
    assign strobe_pair_err = st_r.strobe_err;

    //////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_entry;
        @(posedge clk) disable iff (!rst_sync_r)
        (st_r.mode == XTB_ARMED && power_good_in && external_reset_in_n && !st_r.rst_prev
         && !strap_in.xor_test_strap && !strap_in.primary_present_strap_n) |=> test_mode;
    endproperty
    a_entry: assert property (p_entry) else $error("test mode not entered");

    property p_no_entry;
        @(posedge clk) disable iff (!rst_sync_r)
        (st_r.mode == XTB_ARMED && external_reset_in_n && !st_r.rst_prev
         && strap_in.xor_test_strap) |=> !test_mode;
    endproperty
    a_no_entry: assert property (p_no_entry) else $error("entered with strap high");

    property p_parity;
        @(posedge clk) disable iff (!rst_sync_r)
        (st_nxt.test_mode) |=> (st_r.result == $past(parity));
    endproperty
    a_parity: assert property (p_parity) else $error("chain result mismatch");

    property p_pins;
        @(posedge clk) disable iff (!rst_sync_r)
        test_mode |-> (result_out.bus_speed_select_2 == st_r.result[0]
                       && result_out.bus_speed_select_0 == st_r.result[9]
                       && result_out.xor_test_strap == st_r.result[2]);
    endproperty
    a_pins: assert property (p_pins) else $error("result pin map wrong");

    property p_oe;
        @(posedge clk) disable iff (!rst_sync_r)
        test_mode == (&result_oe);
    endproperty
    a_oe: assert property (p_oe) else $error("result pins not driven");

    property p_ready;
        @(posedge clk) disable iff (!rst_sync_r)
        $rose(test_mode) |-> !test_ready [*8];
    endproperty
    a_ready: assert property (p_ready) else $error("ready too early");

    property p_ready_late;
        @(posedge clk) disable iff (!rst_sync_r)
        (test_mode && st_r.settle == 6'h1f && power_good_in && external_reset_in_n) |=> test_ready;
    endproperty
    a_ready_late: assert property (p_ready_late) else $error("ready missing");

    property p_strobe;
        @(posedge clk) disable iff (!rst_sync_r)
        (test_ready && stb_bad) |=> strobe_pair_err;
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe pairing not flagged");

    property p_idle_quiet;
        @(posedge clk) disable iff (!rst_sync_r)
        !test_mode |-> (st_r.result == '0);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("results outside test mode");

    // Leaving test mode must hand the shared pins back at once, or the board
    // would fight the tester on the strap pins during a later entry
    property p_exit;
        @(posedge clk) disable iff (!rst_sync_r)
        (test_mode && (!power_good_in || !external_reset_in_n)) |=> (!test_mode && result_oe == '0);
    endproperty
    a_exit: assert property (p_exit) else $error("test mode not left");

    // Ready may only follow a full settle count
    property p_ready_count;
        @(posedge clk) disable iff (!rst_sync_r)
        test_ready |-> (test_mode && st_r.settle == SETTLE_CNT_MAX);
    endproperty
    a_ready_count: assert property (p_ready_count) else $error("ready without settle count");

    c_entry: cover property (@(posedge clk) disable iff (!rst_sync_r) $rose(test_mode));
    c_ready: cover property (@(posedge clk) disable iff (!rst_sync_r) $rose(test_ready));
    c_flip:  cover property (@(posedge clk) disable iff (!rst_sync_r) test_ready && $changed(st_r.result));
    c_err:   cover property (@(posedge clk) disable iff (!rst_sync_r) strobe_pair_err);
    c_exit:  cover property (@(posedge clk) disable iff (!rst_sync_r) $fell(test_mode));

endmodule : xtb_xor_tree_test

// *** test/xor_tree_board_test_tb.sv ***
// Testbench: mode entry, refusal, parity of all ten chains, pin map, strobe pairs
module xor_tree_board_test_tb import xtb_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LEN [10] = '{CHAIN0_LEN, CHAIN1_LEN, CHAIN2_LEN, CHAIN3_LEN, 49, 50, 43, 40, 64, 16};
    logic                     clk, nrst, pg, rst_n, brk, mode, ready, perr;
    logic [CHAIN_MAX_LEN-1:0] chain_pins [NUM_CHAINS];
    logic [8:0]               a_t, a_c, b_t, b_c;
    xtb_pins_t                strap, res, oe;
    logic [9:0]               exp;
    logic [31:0]              rng;
    int                       num_errors, samples_checked;
    xtb_xor_tree_test #(.CHAIN4_LEN(LEN[4]), .CHAIN5_LEN(LEN[5]), .CHAIN6_LEN(LEN[6]),
        .CHAIN7_LEN(LEN[7]), .CHAIN8_LEN(LEN[8]), .CHAIN9_LEN(LEN[9])) i_xtb_xor_tree_test (
        .clk(clk), .nrst(nrst), .power_good_in(pg), .external_reset_in_n(rst_n), .strap_in(strap),
        .chain_pins(chain_pins), .chan_a_strobe_true(a_t), .chan_a_strobe_comp(a_c),
        .chan_b_strobe_true(b_t), .chan_b_strobe_comp(b_c), .result_out(res), .result_oe(oe),
        .test_mode(mode), .test_ready(ready), .strobe_pair_err(perr));
    xtb_ate_model i_xtb_ate_model (.clk(clk), .result_out(res), .result_oe(oe), .a_comp(a_c),
        .b_comp(b_c), .pair_break(brk), .power_good_in(pg), .external_reset_in_n(rst_n),
        .strap_in(strap), .a_true(a_t), .b_true(b_t));
    always #25 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    // Parity worked out over the bench's own chain lengths
    function automatic logic [9:0] parity_all();
        logic [9:0] e;
        e = '0;
        for (int k = 0; k < 10; k++)
            for (int i = 0; i < LEN[k]; i++)
                e[k] = e[k] ^ chain_pins[k][i];
        return e;
    endfunction : parity_all
    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (!ok) begin
            num_errors++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask : check
    task automatic conclude();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    initial begin
        #(50 * 90000);
        num_errors++;
        conclude();
    end
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        brk = 1'b0;
        a_c = '0;
        b_c = '0;
        rng = 32'h000105af;
        num_errors = 0;
        samples_checked = 0;
        for (int k = 0; k < 10; k++)
            chain_pins[k] = '0;
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        check(mode === 1'b0 && oe === 10'h000 && res === 10'h000, "outputs before entry");
        i_xtb_ate_model.enter(1'b0);
        check(mode === 1'b1 && ready === 1'b0, "test mode entry");
        @(negedge clk);
        check(ready === 1'b1 && oe === 10'h3ff, "ready with all result pins driven");
        for (int n = 0; n < 300; n++) begin
            for (int k = 0; k < 10; k++)
                for (int w = 0; w < 3; w++) begin
                    rng = xs(rng);
                    chain_pins[k][w*25 +: 25] = rng[24:0];
                end
            a_c = rng[8:0];
            b_c = rng[17:9];
            @(negedge clk);
            exp = parity_all();
            check(res === exp && perr === 1'b0, "chain parity");
            check(res.bus_speed_select_2 === exp[0] && res.xor_test_strap === exp[2]
                && res.bus_speed_select_0 === exp[9], "result pin map");
        end
        for (int k = 0; k < 10; k++) begin
            exp = res ^ (10'h001 << k);
            chain_pins[k][LEN[k]-1] = ~chain_pins[k][LEN[k]-1];
            @(negedge clk);
            check(res === exp, "last member toggle");
            if (LEN[k] < CHAIN_MAX_LEN) begin
                chain_pins[k][LEN[k]] = ~chain_pins[k][LEN[k]];
                @(negedge clk);
                check(res === exp, "pin outside chain changed result");
            end
        end
        brk = 1'b1;
        @(negedge clk);
        brk = 1'b0;
        check(perr === 1'b1, "strobe pair fault not flagged");
        @(negedge clk);
        check(perr === 1'b0, "strobe pair flag stuck");
        i_xtb_ate_model.enter(1'b1);
        check(mode === 1'b0 && oe === 10'h000 && res === 10'h000, "entry with strap high");
        conclude();
    end
endmodule : xor_tree_board_test_tb

// *** test/xtb_ate_model.sv ***
// Tester model: strap-and-reset entry sequence, strobe pairs, shared pin merge
module xtb_ate_model import xtb_pkg::*; (
    input  wire logic               clk,
    input  wire xtb_pkg::xtb_pins_t result_out,
    input  wire xtb_pkg::xtb_pins_t result_oe,
    input  wire logic [8:0]         a_comp,
    input  wire logic [8:0]         b_comp,
    input  wire logic               pair_break,
    output logic                    power_good_in,
    output logic                    external_reset_in_n,
    output xtb_pkg::xtb_pins_t      strap_in,
    output logic [8:0]              a_true,
    output logic [8:0]              b_true
);
    timeunit 1ns;
    timeprecision 1ns;
    xtb_pins_t drv;
    logic      drv_en;
    // Only the true strobe of pair 0 is spoiled, and only on request
    assign a_true = ~a_comp ^ {8'h00, pair_break};
    assign b_true = ~b_comp;
    // Released pins float: show the inverse of the last drive, never a stale copy
    assign strap_in = xtb_pins_t'((result_oe & result_out) | (~result_oe & (drv_en ? drv : ~drv)));
    initial begin
        power_good_in = 1'b0;
        external_reset_in_n = 1'b0;
        drv = '0;
        drv_en = 1'b1;
    end
    task automatic enter(input logic bad);
        @(negedge clk);
        power_good_in = 1'b0;
        external_reset_in_n = 1'b0;
        drv = '0;
        drv.xor_test_strap = bad;
        drv_en = 1'b1;
        repeat (3) @(negedge clk);
        power_good_in = 1'b1;
        repeat (4) @(negedge clk);
        external_reset_in_n = 1'b1;
        @(negedge clk);
        drv_en = 1'b0;
        // Hands back one clock short of the 32; the caller spends the last one checking ready
        repeat (31) @(negedge clk);
    endtask : enter
endmodule : xtb_ate_model
